// ===== design/gpt_defs.svh
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH

// register offsets (word addresses on the register port)
`define GPT_OFS_OUT_LO 8'h00
`define GPT_OFS_OUT_HI 8'h01
`define GPT_OFS_PRESET1 8'h02
`define GPT_OFS_PRESET2 8'h03
`define GPT_OFS_AVG_CFG 8'h04
`define GPT_OFS_INT_HI 8'h05
`define GPT_OFS_INT_LO 8'h06
`define GPT_OFS_R1_HI 8'h07
`define GPT_OFS_R1_LO 8'h08
`define GPT_OFS_R2_HI 8'h09
`define GPT_OFS_R2_LO 8'h0A
`define GPT_OFS_MON_CTL 8'h0B
`define GPT_OFS_INT_STAT 8'h0C
`define GPT_OFS_R1_STAT 8'h0D
`define GPT_OFS_R2_STAT 8'h0E
`define GPT_OFS_IRQ_MASK 8'h0F

// field positions
`define GPT_OUT_LO_MSB 15
`define GPT_OUT_HI_MSB 3
`define GPT_CODE_MSB 11
`define GPT_AVG_INT_LSB 0
`define GPT_AVG_R1_LSB 2
`define GPT_AVG_R2_LSB 4
`define GPT_MON_EN_LSB 8
`define GPT_MON_EN_MSB 10
`define GPT_STAT_HI_BIT 2
`define GPT_STAT_LO_BIT 1

// reset values
`define GPT_RST_OUT 20'h0_0000
`define GPT_RST_CODE 12'h000
`define GPT_RST_AVG 6'h00
`define GPT_RST_LIMIT 12'h000
`define GPT_RST_MON_EN 3'h0
`define GPT_RST_MASK 6'h00

// averaging: depth code n selects 4 << n samples, shift 2 + n
`define GPT_AVG_BASE_CNT 6'h04
`define GPT_AVG_BASE_SHIFT 3'h2

`endif

// ===== design/gpt_monitor.sv
`timescale 1ns/1ns
`include "gpt_defs.svh"

module gpt_monitor
  import gpt_pkg::*;
#(
  parameter int SAMPLE_W = 12
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic enable_i,
  input wire logic [1:0] depth_i,
  input wire logic [SAMPLE_W-1:0] hi_limit_i,
  input wire logic [SAMPLE_W-1:0] lo_limit_i,
  // raw samples
  input wire gpt_sample_t sample_i,
  // results
  output logic [SAMPLE_W-1:0] result_o,
  output logic done_o,
  output gpt_alarm_t alarm_o
);

  localparam int SUM_W = SAMPLE_W + 5;

  logic [5:0] count_q;
  logic signed [SUM_W-1:0] sum_q;
  logic signed [SUM_W-1:0] sum_d;
  logic signed [SUM_W-1:0] avg_full;
  logic signed [SAMPLE_W-1:0] avg;
  logic [5:0] target;
  logic last;

  assign target = `GPT_AVG_BASE_CNT << depth_i;
  assign sum_d = sum_q + SUM_W'($signed(sample_i.value));
  assign last = sample_i.valid && ((count_q + 6'h01) == target);
  assign avg_full = sum_d >>> (`GPT_AVG_BASE_SHIFT + {1'b0, depth_i});
  assign avg = avg_full[SAMPLE_W-1:0];

  // accumulation only while enabled
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_q <= 6'h00;
      sum_q <= '0;
    end
    else if (!enable_i || last) // [R15]
    begin
      count_q <= 6'h00;
      sum_q <= '0;
    end
    else if (sample_i.valid)
    begin
      count_q <= count_q + 6'h01;
      sum_q <= sum_d;
    end
  end

  // signed limit compare on each finished average
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      result_o <= '0;
      done_o <= 1'b0;
      alarm_o <= '0;
    end
    else
    begin
      done_o <= enable_i && last; // [R17]
      alarm_o.hi <= enable_i && last && (avg > $signed(hi_limit_i)); // [R14]
      alarm_o.lo <= enable_i && last && (avg < $signed(lo_limit_i)); // [R14]
      if (enable_i && last)
      begin
        result_o <= avg;
      end
    end
  end

endmodule // gpt_monitor

// ===== design/gpt_pkg.sv
package gpt_pkg;

  typedef struct packed {
    logic hi;
    logic lo;
  } gpt_alarm_t;

  typedef struct packed {
    logic valid;
    logic [11:0] value;
  } gpt_sample_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } gpt_bus_req_t;

endpackage

// ===== design/gpt_regs.sv
// Overview of operation
// [R1] output levels: ports 0-15 in low register 15:0, ports 16-19 high register 3:0
// [R2] a port selected as general output drives its stored level bit
// [R3] two readable writable 12-bit preset codes offered to DAC-mode ports
// [R4] preset writes never touch any per-port DAC code register
// [R5] internal averaging depth bits 1:0 select 4, 8, 16, 32 samples
// [R6] first remote averaging depth bits 3:2, same coding
// [R7] second remote averaging depth bits 5:4, same coding
// [R8] internal status bit 2 set when temperature above internal high limit
// [R9] internal status bit 1 set when temperature below internal low limit
// [R10] first remote status bit 2 set when temperature above its high limit
// [R11] first remote status bit 1 set when temperature below its low limit
// [R12] second remote status bit 2 set when temperature above its high limit
// [R13] second remote status bit 1 set when temperature below its low limit
// [R14] limits are signed 0.125 degree steps, compared signed
// [R15] each monitor runs only while its enable bit 8, 9 or 10 is set
// [R16] level bits of non-output ports stay stored, readable, and drive nothing
// [R17] limits compared whenever an enabled monitor finishes an average
`timescale 1ns/1ns
`include "gpt_defs.svh"

module gpt_regs
  import gpt_pkg::*;
#(
  parameter int NUM_PORTS = 20,
  parameter int NUM_MON = 3,
  parameter int CODE_W = 12
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire gpt_bus_req_t bus_req_i,
  output logic [15:0] bus_rdata_o,
  // port function selection from the configuration block
  input wire logic [NUM_PORTS-1:0] port_is_output_i,
  // output pins
  output logic [NUM_PORTS-1:0] port_level_o,
  output logic [NUM_PORTS-1:0] port_oe_o,
  // preset codes to the DAC path
  output logic [CODE_W-1:0] preset_code_one_o,
  output logic [CODE_W-1:0] preset_code_two_o,
  // temperature sample streams: internal, remote one, remote two
  input wire gpt_sample_t temp_sample_i [NUM_MON],
  output logic [NUM_MON-1:0] monitor_run_o,
  output logic [CODE_W-1:0] temp_result_o [NUM_MON],
  output logic [NUM_MON-1:0] temp_done_o,
  // interrupt
  output logic irq_o
);

  logic [NUM_PORTS-1:0] out_level_q;
  logic [CODE_W-1:0] preset_one_q;
  logic [CODE_W-1:0] preset_two_q;
  logic [5:0] avg_cfg_q;
  logic [CODE_W-1:0] hi_limit_q [NUM_MON];
  logic [CODE_W-1:0] lo_limit_q [NUM_MON];
  logic [NUM_MON-1:0] mon_en_q;
  gpt_alarm_t stat_q [NUM_MON];
  logic [2*NUM_MON-1:0] mask_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  gpt_alarm_t alarm [NUM_MON];
  logic [1:0] depth [NUM_MON];
  logic [2*NUM_MON-1:0] pending;
  logic wr;
  logic [7:0] addr;
  logic [15:0] wdata;

  assign wr = bus_req_i.we;
  assign addr = bus_req_i.addr;
  assign wdata = bus_req_i.wdata;

  // output level storage
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      out_level_q <= `GPT_RST_OUT;
    end
    else if (wr && addr == `GPT_OFS_OUT_LO)
    begin
      out_level_q[`GPT_OUT_LO_MSB:0] <= wdata[`GPT_OUT_LO_MSB:0]; // [R1]
    end
    else if (wr && addr == `GPT_OFS_OUT_HI)
    begin
      out_level_q[NUM_PORTS-1:`GPT_OUT_LO_MSB+1] <= wdata[`GPT_OUT_HI_MSB:0]; // [R1]
    end
  end

  // pins: only output-selected ports are driven
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port_level_o <= '0;
      port_oe_o <= '0;
    end
    else
    begin
      port_level_o <= out_level_q & port_is_output_i; // [R2] [R16]
      port_oe_o <= port_is_output_i; // [R16]
    end
  end

  // preset codes: held here only, no path into per-port code storage
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      preset_one_q <= `GPT_RST_CODE;
      preset_two_q <= `GPT_RST_CODE;
    end
    else if (wr && addr == `GPT_OFS_PRESET1)
    begin
      preset_one_q <= wdata[`GPT_CODE_MSB:0]; // [R3] [R4]
    end
    else if (wr && addr == `GPT_OFS_PRESET2)
    begin
      preset_two_q <= wdata[`GPT_CODE_MSB:0]; // [R3] [R4]
    end
  end

  assign preset_code_one_o = preset_one_q;
  assign preset_code_two_o = preset_two_q;

  // averaging configuration and monitor enables
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      avg_cfg_q <= `GPT_RST_AVG;
      mon_en_q <= `GPT_RST_MON_EN;
      mask_q <= `GPT_RST_MASK;
    end
    else if (wr)
    begin
      if (addr == `GPT_OFS_AVG_CFG)
      begin
        avg_cfg_q <= wdata[5:0];
      end
      if (addr == `GPT_OFS_MON_CTL)
      begin
        mon_en_q <= wdata[`GPT_MON_EN_MSB:`GPT_MON_EN_LSB];
      end
      if (addr == `GPT_OFS_IRQ_MASK)
      begin
        mask_q <= wdata[2*NUM_MON-1:0];
      end
    end
  end

  assign depth[0] = avg_cfg_q[`GPT_AVG_INT_LSB+1:`GPT_AVG_INT_LSB]; // [R5]
  assign depth[1] = avg_cfg_q[`GPT_AVG_R1_LSB+1:`GPT_AVG_R1_LSB]; // [R6]
  assign depth[2] = avg_cfg_q[`GPT_AVG_R2_LSB+1:`GPT_AVG_R2_LSB]; // [R7]
  assign monitor_run_o = mon_en_q; // [R15]

  // limit registers, signed 0.125 degree codes
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int m = 0; m < NUM_MON; m++)
      begin
        hi_limit_q[m] <= `GPT_RST_LIMIT;
        lo_limit_q[m] <= `GPT_RST_LIMIT;
      end
    end
    else if (wr)
    begin
      case (addr)
        `GPT_OFS_INT_HI: hi_limit_q[0] <= wdata[`GPT_CODE_MSB:0]; // [R14]
        `GPT_OFS_INT_LO: lo_limit_q[0] <= wdata[`GPT_CODE_MSB:0]; // [R14]
        `GPT_OFS_R1_HI: hi_limit_q[1] <= wdata[`GPT_CODE_MSB:0];
        `GPT_OFS_R1_LO: lo_limit_q[1] <= wdata[`GPT_CODE_MSB:0];
        `GPT_OFS_R2_HI: hi_limit_q[2] <= wdata[`GPT_CODE_MSB:0];
        `GPT_OFS_R2_LO: lo_limit_q[2] <= wdata[`GPT_CODE_MSB:0];
        default: ;
      endcase
    end
  end

  // one averaging monitor per sensor
  for (genvar m = 0; m < NUM_MON; m++)
  begin : g_mon
    gpt_monitor #(
      .SAMPLE_W(CODE_W)
    ) u_mon (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(mon_en_q[m]), // [R15]
      .depth_i(depth[m]),
      .hi_limit_i(hi_limit_q[m]),
      .lo_limit_i(lo_limit_q[m]),
      .sample_i(temp_sample_i[m]),
      .result_o(temp_result_o[m]),
      .done_o(temp_done_o[m]), // [R17]
      .alarm_o(alarm[m])
    );
  end

  // sticky alarms, write one to clear, a new alarm beats the clear
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int m = 0; m < NUM_MON; m++)
      begin
        stat_q[m] <= '0;
      end
    end
    else
    begin
      for (int m = 0; m < NUM_MON; m++)
      begin
        if (wr && addr == (`GPT_OFS_INT_STAT + 8'(m)))
        begin
          if (wdata[`GPT_STAT_HI_BIT])
          begin
            stat_q[m].hi <= 1'b0;
          end
          if (wdata[`GPT_STAT_LO_BIT])
          begin
            stat_q[m].lo <= 1'b0;
          end
        end
        if (alarm[m].hi)
        begin
          stat_q[m].hi <= 1'b1; // [R8] [R10] [R12]
        end
        if (alarm[m].lo)
        begin
          stat_q[m].lo <= 1'b1; // [R9] [R11] [R13]
        end
      end
    end
  end

  always_comb
  begin
    for (int m = 0; m < NUM_MON; m++)
    begin
      pending[2*m] = stat_q[m].lo & mask_q[2*m];
      pending[2*m+1] = stat_q[m].hi & mask_q[2*m+1];
    end
  end

  assign irq_o = |pending;

  // read multiplexer
  always_comb
  begin
    rdata_d = 16'h0000;
    case (addr)
      `GPT_OFS_OUT_LO: rdata_d = out_level_q[`GPT_OUT_LO_MSB:0]; // [R16]
      `GPT_OFS_OUT_HI: rdata_d = {12'h000, out_level_q[NUM_PORTS-1:`GPT_OUT_LO_MSB+1]};
      `GPT_OFS_PRESET1: rdata_d = {4'h0, preset_one_q};
      `GPT_OFS_PRESET2: rdata_d = {4'h0, preset_two_q};
      `GPT_OFS_AVG_CFG: rdata_d = {10'h000, avg_cfg_q};
      `GPT_OFS_INT_HI: rdata_d = {4'h0, hi_limit_q[0]};
      `GPT_OFS_INT_LO: rdata_d = {4'h0, lo_limit_q[0]};
      `GPT_OFS_R1_HI: rdata_d = {4'h0, hi_limit_q[1]};
      `GPT_OFS_R1_LO: rdata_d = {4'h0, lo_limit_q[1]};
      `GPT_OFS_R2_HI: rdata_d = {4'h0, hi_limit_q[2]};
      `GPT_OFS_R2_LO: rdata_d = {4'h0, lo_limit_q[2]};
      `GPT_OFS_MON_CTL: rdata_d = {5'h00, mon_en_q, 8'h00};
      `GPT_OFS_INT_STAT: rdata_d = {13'h0000, stat_q[0].hi, stat_q[0].lo, 1'b0};
      `GPT_OFS_R1_STAT: rdata_d = {13'h0000, stat_q[1].hi, stat_q[1].lo, 1'b0};
      `GPT_OFS_R2_STAT: rdata_d = {13'h0000, stat_q[2].hi, stat_q[2].lo, 1'b0};
      `GPT_OFS_IRQ_MASK: rdata_d = {10'h000, mask_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= 16'h0000;
    end
    else if (bus_req_i.re)
    begin
      rdata_q <= rdata_d;
    end
    else
    begin
      rdata_q <= 16'h0000;
    end
  end

  assign bus_rdata_o = rdata_q;

  a_gpo_drive: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 port_oe_o[19] |-> port_level_o[19] == $past(out_level_q[19])) // [R2]
    else $error("output port level does not follow stored bit");

  a_gpo_masked: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !port_oe_o[0] |-> !port_level_o[0]) // [R16]
    else $error("unselected port shows a level");

  a_high_word_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr && addr == `GPT_OFS_OUT_HI |=> out_level_q[19:16] == $past(wdata[3:0])
      && $stable(out_level_q[15:0])) // [R1]
    else $error("high level word write misplaced");

  a_preset_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !(wr && addr == `GPT_OFS_PRESET1) |=> $stable(preset_code_one_o)) // [R4]
    else $error("preset code changed without its write");

  a_preset_read: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    bus_req_i.re && addr == `GPT_OFS_PRESET2 |=> bus_rdata_o == {4'h0, preset_code_two_o}
      || $past(wr)) // [R3]
    else $error("preset code read back wrong");

  a_hi_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    alarm[0].hi |=> stat_q[0].hi ##1 (stat_q[0].hi
      || $past(wr && addr == `GPT_OFS_INT_STAT && wdata[`GPT_STAT_HI_BIT]))) // [R8]
    else $error("internal high alarm not held");

  a_lo_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    alarm[2].lo |=> stat_q[2].lo) // [R13]
    else $error("second remote low alarm lost");

  a_hi_cause: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(stat_q[1].hi) |-> $past(alarm[1].hi)) // [R10]
    else $error("remote one high flag without alarm");

  a_mon_idle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !mon_en_q[1] && $past(!mon_en_q[1]) |-> !temp_done_o[1] && !alarm[1].lo) // [R15]
    else $error("disabled monitor produced a result");

  a_irq_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    stat_q[0].lo && mask_q[0] |-> irq_o) // [R9]
    else $error("unmasked alarm without interrupt");

  a_read_window: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !bus_req_i.re |=> bus_rdata_o == 16'h0000)
    else $error("read data outside its cycle");

endmodule // gpt_regs

// ===== testbench/gpt_sensor_model.sv
`timescale 1ns/1ns

module gpt_sensor_model
  import gpt_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // sample streams: internal, remote one, remote two
  output gpt_sample_t samp_o [3]
);
  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      samp_o[i] = '{valid: 1'b0, value: 12'hA5A};
    end
  end

  // alternating v and v+1 so a floored average lands on v
  task automatic send(input int m, input logic [11:0] v, input int n);
    for (int k = 0; k < n; k++)
    begin
      @(posedge core_clk_i);
      samp_o[m] <= '{valid: 1'b1, value: v + 12'(k % 2)};
    end
    @(posedge core_clk_i);
    // idle value is junk, never the last sample
    samp_o[m] <= '{valid: 1'b0, value: ~v};
  endtask
endmodule // gpt_sensor_model

// ===== testbench/tb.sv
`timescale 1ns/1ns

module tb;
  import gpt_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  gpt_bus_req_t req = '0;
  logic [19:0] sel = '0;
  gpt_sample_t samp [3];
  logic [15:0] rdata;
  logic [19:0] lvl;
  logic [19:0] oe;
  logic [11:0] pc1;
  logic [11:0] pc2;
  logic [2:0] run;
  logic [2:0] done;
  logic [11:0] res [3];
  logic irq;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_done = 0;
  logic [15:0] rw_mask [16] = '{16'hFFFF, 16'h000F, 16'h0FFF, 16'h0FFF, 16'h003F, 16'h0FFF,
    16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0700, 16'h0000, 16'h0000, 16'h0000,
    16'h003F};

  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  gpt_regs u_gpt_regs (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_req_i(req), .bus_rdata_o(rdata),
    .port_is_output_i(sel), .port_level_o(lvl), .port_oe_o(oe), .preset_code_one_o(pc1),
    .preset_code_two_o(pc2), .temp_sample_i(samp), .monitor_run_o(run), .temp_result_o(res),
    .temp_done_o(done), .irq_o(irq)
  );

  gpt_sensor_model u_gpt_sensor_model (.core_clk_i(core_clk_i), .samp_o(samp));

  task automatic summarize;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  // finished averages, to catch an early or extra result
  always @(posedge core_clk_i)
  begin
    if ((|done) === 1'b1)
      n_done <= n_done + 1;
  end

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.we <= 1'b1;
    @(posedge core_clk_i);
    req.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    req.addr <= a;
    req.re <= 1'b1;
    @(posedge core_clk_i);
    req.re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_done(input int m, output logic ok);
    ok = 1'b0;
    #1;
    for (int k = 0; k < 8 && !ok; k++)
    begin
      if (done[m] === 1'b1)
        ok = 1'b1;
      else
      begin
        @(posedge core_clk_i);
        #1;
      end
    end
  endtask

  function automatic logic [2:0] exp_stat(input logic signed [11:0] v, h, l);
    return {v > h, v < l, 1'b0};
  endfunction

  initial
  begin
    logic [15:0] d;
    logic [15:0] x;
    logic [15:0] y;
    logic [11:0] hi;
    logic [11:0] lo;
    logic [11:0] v;
    logic [5:0] mk;
    logic [2:0] s;
    logic ok;
    int m;
    int dp;
    int nd0;
    void'($urandom(7));
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    // reset values, address 16 unmapped
    for (int a = 0; a < 17; a++)
    begin
      rd(8'(a), d);
      cmp(d, 20'h0_0000);
    end
    for (int a = 0; a < 16; a++)
    begin
      if (a < 12 || a == 15)
      begin
        x = 16'($urandom);
        wr(8'(a), x);
        rd(8'(a), d);
        cmp(d, x & rw_mask[a]);
      end
    end
    wr(8'h20, 16'hFFFF);
    rd(8'h20, d);
    cmp(d, 20'h0_0000);
    repeat (4)
    begin
      @(posedge core_clk_i);
      sel <= 20'($urandom);
      x = 16'($urandom);
      y = 16'($urandom);
      wr(8'h00, x);
      wr(8'h01, y);
      @(posedge core_clk_i);
      #1 cmp(lvl, {y[3:0], x} & sel);
      cmp(oe, sel);
      rd(8'h00, d);
      cmp(d, x);
      wr(8'h02, y);
      wr(8'h03, x);
      #1 cmp({pc2, pc1[7:0]}, {x[11:0], y[7:0]});
      cmp(pc1, y[11:0]);
      cmp(lvl, {y[3:0], x} & sel);
    end
    for (int i = 0; i < 12; i++)
    begin
      m = i % 3;
      dp = i / 3;
      hi = 12'($urandom_range(200));
      lo = 12'h000 - 12'($urandom_range(200));
      case (i % 4)
        0: v = hi + 12'h001;
        1: v = lo - 12'h001;
        2: v = hi;
        default: v = 12'($urandom_range(400)) - 12'd200;
      endcase
      mk = 6'($urandom);
      wr(8'(5 + 2 * m), {4'h0, hi});
      wr(8'(6 + 2 * m), {4'h0, lo});
      wr(8'h04, 16'(dp << (2 * m)));
      wr(8'h0B, 16'(1 << (8 + m)));
      wr(8'h0F, {10'h000, mk});
      nd0 = n_done;
      u_gpt_sensor_model.send(m, v, 4 << dp);
      wait_done(m, ok);
      cmp(ok, 1'b1);
      cmp(res[m], v);
      s = exp_stat(v, hi, lo);
      rd(8'(12 + m), d);
      cmp(d, s);
      cmp(20'(n_done - nd0), 20'h0_0001);
      cmp(irq, (s[1] & mk[2 * m]) | (s[2] & mk[2 * m + 1]));
      wr(8'(12 + m), 16'h0006);
      #1 cmp(irq, 1'b0);
    end
    // monitor zero disabled: its samples are ignored
    cmp(run, 3'b100);
    nd0 = n_done;
    u_gpt_sensor_model.send(0, 12'h010, 4);
    wait_done(0, ok);
    cmp(ok, 1'b0);
    cmp(20'(n_done - nd0), 20'h0_0000);
    summarize();
  end
endmodule // tb
